// ### rtl/gain_ctrl_consts.vh
`ifndef GAIN_CTRL_CONSTS_VH
`define GAIN_CTRL_CONSTS_VH

// Interface select codes {iface_sel_hi, iface_sel_lo}
`define IFACE_PARALLEL     2'b00
`define IFACE_SERIAL       2'b01

// Serial control word layout
`define WORD_BITS          16
`define WORD_RW_BIT        8
`define WORD_QSTEP_HI_BIT  7
`define WORD_QSTEP_LO_BIT  6
`define WORD_GAIN_MSB      5
`define WORD_RESET_VAL     16'h0000

// Gain code range
`define GAIN_CODE_MAX_ATTN 6'h3F
`define GAIN_CODE_FLOOR    6'h23
`define GAIN_RESET_VAL     6'h3F
`define AMP_STEPS          6'h0C
`define AMP_RED_MAX        4'hC
`define WORD_CNT_FULL      5'h10
`define WORD_CNT_OVER      5'h11
// Synchroniser reset: both active-low selects idle high
`define SYNC_RESET_VAL     15'h0300
`define ATTN_MAX_DB        5'h17

`endif

// ### rtl/gain_channel.v
`timescale 1ns/1ps
// One channel: applies quick attenuation, clamps, splits amplifier/attenuator.
`include "gain_ctrl_consts.vh"
module gain_channel (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire [5:0] code_i,
   input  wire       quick_en_i,
   input  wire [1:0] quick_step_i,
   input  wire       power_on_i,
   output reg  [5:0] eff_code_o,
   output reg  [3:0] amp_red_o,
   output reg  [4:0] attn_db_o,
   output reg        enable_o
);
   reg [6:0] sum;
   reg [5:0] eff;
   always @* begin
      sum = {1'b0, code_i};
      if (quick_en_i)
         sum = {1'b0, code_i} + (7'h02 << quick_step_i);
      eff = (sum > {1'b0, `GAIN_CODE_FLOOR}) ? `GAIN_CODE_FLOOR : sum[5:0];
   end
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         eff_code_o <= `GAIN_RESET_VAL;
         amp_red_o  <= 4'h0;
         attn_db_o  <= 5'h00;
         enable_o   <= 1'b0;
      end else begin
         eff_code_o <= eff;
         enable_o   <= power_on_i;
         if (eff <= `AMP_STEPS) begin
            amp_red_o <= eff[3:0];
            attn_db_o <= 5'h00;
         end else begin
            amp_red_o <= `AMP_RED_MAX;
            // Modulo-32 wrap keeps codes 32 to 35 exact
            attn_db_o <= eff[4:0] - 5'h0C;
         end
      end
   end
endmodule

// ### rtl/dual_gain_control_interface.v
`timescale 1ns/1ps
`include "gain_ctrl_consts.vh"
module dual_gain_control_interface (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       iface_sel_hi_i,
   input  wire       iface_sel_lo_i,
   input  wire       perf_select_i,
   input  wire       power_on_ch1_i,
   input  wire       power_on_ch2_i,
   input  wire [5:0] par_gain_ch1_i,
   input  wire [5:0] par_gain_ch2_i,
   input  wire       hold_ch1_i,
   input  wire       hold_ch2_i,
   input  wire       select_n_ch1_i,
   input  wire       select_n_ch2_i,
   input  wire       sclk_i,
   input  wire       sdio_i,
   output reg        sdio_o,
   output reg        sdio_oe_o,
   input  wire       quick_atten_pin_ch1_i,
   input  wire       quick_atten_pin_ch2_i,
   input  wire       step_pulse_ch1_i,
   input  wire       step_pulse_ch2_i,
   input  wire       step_direction_ch1_i,
   input  wire       step_direction_ch2_i,
   input  wire       step_size_hi_i,
   input  wire       step_size_lo_i,
   output wire [5:0] gain_code_ch1_o,
   output wire [5:0] gain_code_ch2_o,
   output wire [3:0] amp_red_ch1_o,
   output wire [3:0] amp_red_ch2_o,
   output wire [4:0] attn_db_ch1_o,
   output wire [4:0] attn_db_ch2_o,
   output wire       enable_ch1_o,
   output wire       enable_ch2_o,
   output reg        high_perf_o
);
   localparam NS = 15;
   // Two-stage synchronisers for every pin
   wire [NS-1:0] raw = {iface_sel_hi_i, iface_sel_lo_i, perf_select_i, hold_ch1_i, hold_ch2_i,
                        select_n_ch1_i, select_n_ch2_i, sclk_i, sdio_i,
                        step_pulse_ch1_i, step_pulse_ch2_i,
                        step_direction_ch1_i, step_direction_ch2_i,
                        step_size_hi_i, step_size_lo_i};
   reg  [NS-1:0] s1_r;
   reg  [NS-1:0] s2_r;
   reg  [11:0]   pg1_r;
   reg  [11:0]   pg2_r;
   reg  [1:0]    qa1_r;
   reg  [1:0]    qa2_r;
   reg  [1:0]    pw1_r;
   reg  [1:0]    pw2_r;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         // Selects reset to their idle level, so no false frame edge follows reset
         s1_r  <= `SYNC_RESET_VAL;
         s2_r  <= `SYNC_RESET_VAL;
         pg1_r <= 12'h000;
         pg2_r <= 12'h000;
         qa1_r <= 2'h0;
         qa2_r <= 2'h0;
         pw1_r <= 2'h0;
         pw2_r <= 2'h0;
      end else begin
         s1_r  <= raw;
         s2_r  <= s1_r;
         pg1_r <= {pg1_r[5:0], par_gain_ch1_i};
         pg2_r <= {pg2_r[5:0], par_gain_ch2_i};
         qa1_r <= {qa1_r[0], quick_atten_pin_ch1_i};
         qa2_r <= {qa2_r[0], quick_atten_pin_ch2_i};
         pw1_r <= {pw1_r[0], power_on_ch1_i};
         pw2_r <= {pw2_r[0], power_on_ch2_i};
      end
   end
   wire [1:0] mode  = s2_r[14:13];
   wire       hold1 = s2_r[11];
   wire       hold2 = s2_r[10];
   wire       sel1  = ~s2_r[9];
   wire       sel2  = ~s2_r[8];
   wire       sck   = s2_r[7];
   wire       sdi   = s2_r[6];
   wire [1:0] pulse = s2_r[5:4];
   wire [1:0] dir   = s2_r[3:2];
   wire [1:0] gstep = s2_r[1:0];
   wire       is_par = (mode == `IFACE_PARALLEL);
   wire       is_ser = (mode == `IFACE_SERIAL);
   wire       is_ud  = mode[1];

   // Serial shifter and edge tracking
   reg        sck_d_r;
   reg        any_sel_d_r;
   reg [15:0] shift_r;
   reg [4:0]  cnt_r;
   reg [15:0] word1_r;
   reg [15:0] word2_r;
   reg        rd_arm1_r;
   reg        rd_arm2_r;
   reg        rd_act_r;
   reg [15:0] rd_sh_r;
   reg [5:0]  code1_r;
   reg [5:0]  code2_r;
   reg [1:0]  pulse_d_r;
   reg [1:0]  dir_rise_r;
   reg        sel1_d_r;
   reg        sel2_d_r;
   wire       any_sel  = sel1 | sel2;
   wire       sck_rise = sck & ~sck_d_r;
   wire       sck_fall = ~sck & sck_d_r;
   wire       frame_start = any_sel & ~any_sel_d_r;
   wire       frame_end   = ~any_sel & any_sel_d_r;
   // Only a single-channel select may start a readback frame
   wire       rd_start = frame_start & (sel1 ^ sel2) &
                         ((sel1 & rd_arm1_r) | (sel2 & rd_arm2_r));
   wire [3:0] ustep = 4'h1 << gstep;

   function [5:0] step_code;
      input [5:0] code;
      input       down;
      input [3:0] st;
      reg   [6:0] t;
      begin
         t = down ? ({1'b0, code} + {3'h0, st}) : ({1'b0, code} - {3'h0, st});
         if (down && t > {1'b0, `GAIN_CODE_MAX_ATTN})
            step_code = `GAIN_CODE_MAX_ATTN;
         else if (!down && ({3'h0, st} > {1'b0, code}))
            step_code = 6'h00;
         else
            step_code = t[5:0];
      end
   endfunction

   integer i;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sck_d_r     <= 1'b0;
         any_sel_d_r <= 1'b0;
         shift_r     <= `WORD_RESET_VAL;
         cnt_r       <= 5'h00;
         word1_r     <= `WORD_RESET_VAL;
         word2_r     <= `WORD_RESET_VAL;
         rd_arm1_r   <= 1'b0;
         rd_arm2_r   <= 1'b0;
         rd_act_r    <= 1'b0;
         rd_sh_r     <= `WORD_RESET_VAL;
         sdio_o      <= 1'b0;
         sdio_oe_o   <= 1'b0;
         code1_r     <= `GAIN_RESET_VAL;
         code2_r     <= `GAIN_RESET_VAL;
         pulse_d_r   <= 2'h0;
         dir_rise_r  <= 2'h0;
         high_perf_o <= 1'b0;
      end else begin
         sck_d_r     <= sck;
         any_sel_d_r <= any_sel;
         pulse_d_r   <= pulse;
         high_perf_o <= s2_r[12];
         if (is_ser) begin
            if (frame_start) begin
               cnt_r    <= 5'h00;
               rd_act_r <= rd_start;
               rd_sh_r  <= sel1 ? word1_r : word2_r;
               if (rd_start) begin
                  rd_arm1_r <= 1'b0;
                  rd_arm2_r <= 1'b0;
               end
            end else if (any_sel && sck_rise) begin
               if (rd_act_r) begin
                  sdio_oe_o <= 1'b1;
                  sdio_o    <= rd_sh_r[15];
                  rd_sh_r   <= {rd_sh_r[14:0], 1'b0};
               end else begin
                  shift_r <= {shift_r[14:0], sdi};
                  // Saturate past 16 so an over-long frame is still refused
                  if (cnt_r != `WORD_CNT_OVER)
                     cnt_r <= cnt_r + 5'h01;
               end
            end
            if (frame_end) begin
               sdio_oe_o <= 1'b0;
               rd_act_r  <= 1'b0;
               // Short or long frames are discarded
               if (!rd_act_r && cnt_r == `WORD_CNT_FULL) begin
                  if (sel1_d_r) begin
                     word1_r   <= shift_r;
                     rd_arm1_r <= shift_r[`WORD_RW_BIT];
                  end
                  if (sel2_d_r) begin
                     word2_r   <= shift_r;
                     rd_arm2_r <= shift_r[`WORD_RW_BIT];
                  end
               end
            end
            code1_r <= word1_r[`WORD_GAIN_MSB:0];
            code2_r <= word2_r[`WORD_GAIN_MSB:0];
         end else begin
            sdio_oe_o <= 1'b0;
            rd_act_r  <= 1'b0;
         end
         if (is_par) begin
            if (!hold1)
               code1_r <= pg1_r[11:6];
            if (!hold2)
               code2_r <= pg2_r[11:6];
         end
         if (is_ud) begin
            for (i = 0; i < 2; i = i + 1) begin
               if (pulse[i] & ~pulse_d_r[i])
                  dir_rise_r[i] <= dir[i];
            end
            if (~pulse[1] & pulse_d_r[1]) begin
               if (dir[1] != dir_rise_r[1])
                  code1_r <= `GAIN_RESET_VAL;
               else
                  code1_r <= step_code(code1_r, dir[1], ustep);
            end
            if (~pulse[0] & pulse_d_r[0]) begin
               if (dir[0] != dir_rise_r[0])
                  code2_r <= `GAIN_RESET_VAL;
               else
                  code2_r <= step_code(code2_r, dir[0], ustep);
            end
         end
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel1_d_r <= 1'b0;
         sel2_d_r <= 1'b0;
      end else begin
         sel1_d_r <= sel1;
         sel2_d_r <= sel2;
      end
   end

   // Quick attenuation only acts in serial mode
   wire qa1 = is_ser & qa1_r[1];
   wire qa2 = is_ser & qa2_r[1];

   gain_channel u_ch1 (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .code_i       (code1_r),
      .quick_en_i   (qa1),
      .quick_step_i (word1_r[`WORD_QSTEP_HI_BIT:`WORD_QSTEP_LO_BIT]),
      .power_on_i   (pw1_r[1]),
      .eff_code_o   (gain_code_ch1_o),
      .amp_red_o    (amp_red_ch1_o),
      .attn_db_o    (attn_db_ch1_o),
      .enable_o     (enable_ch1_o)
   );
   gain_channel u_ch2 (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .code_i       (code2_r),
      .quick_en_i   (qa2),
      .quick_step_i (word2_r[`WORD_QSTEP_HI_BIT:`WORD_QSTEP_LO_BIT]),
      .power_on_i   (pw2_r[1]),
      .eff_code_o   (gain_code_ch2_o),
      .amp_red_o    (amp_red_ch2_o),
      .attn_db_o    (attn_db_ch2_o),
      .enable_o     (enable_ch2_o)
   );
endmodule

// ### dv/gain_ctrl_properties.sv
`timescale 1ns/1ps
module gain_ctrl_checker (
   input wire       clk_i,
   input wire       rst_i,
   input wire       iface_sel_hi_i,
   input wire       iface_sel_lo_i,
   input wire       perf_select_i,
   input wire       power_on_ch1_i,
   input wire       hold_ch1_i,
   input wire       select_n_ch1_i,
   input wire       select_n_ch2_i,
   input wire       step_pulse_ch1_i,
   input wire       sdio_oe_o,
   input wire [5:0] gain_code_ch1_o,
   input wire [3:0] amp_red_ch1_o,
   input wire [4:0] attn_db_ch1_o,
   input wire       enable_ch1_o,
   input wire       high_perf_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Pins pass a synchroniser, so levels are given time to settle
   power_up_a: assert property (power_on_ch1_i [*6] |-> enable_ch1_o)
      else $error("enable late");
   perf_mode_a: assert property (perf_select_i [*6] |-> high_perf_o)
      else $error("perf late");
   amp_only_a: assert property (gain_code_ch1_o <= 6'h0C |-> attn_db_ch1_o == 5'h00
      && amp_red_ch1_o == gain_code_ch1_o[3:0]) else $error("amp split");
   attn_split_a: assert property (gain_code_ch1_o > 6'h0C && gain_code_ch1_o < 6'h24 |->
      amp_red_ch1_o == 4'hC && {1'b0, attn_db_ch1_o} == gain_code_ch1_o - 6'h0C)
      else $error("attn split");
   hold_code_a: assert property ((!iface_sel_hi_i && !iface_sel_lo_i && hold_ch1_i) [*8]
      |-> $stable(gain_code_ch1_o)) else $error("held code moved");
   idle_line_a: assert property ((select_n_ch1_i && select_n_ch2_i) [*4] |-> !sdio_oe_o)
      else $error("line driven idle");
   dual_read_a: assert property ((!select_n_ch1_i && !select_n_ch2_i) [*4] |-> !sdio_oe_o)
      else $error("dual read");
   step_idle_a: assert property ((iface_sel_hi_i && !step_pulse_ch1_i) [*8]
      |-> $stable(gain_code_ch1_o)) else $error("step moved");
   cover property (!select_n_ch1_i && !select_n_ch2_i);
   cover property (sdio_oe_o);
   cover property (iface_sel_hi_i && step_pulse_ch1_i);
endmodule
bind dual_gain_control_interface gain_ctrl_checker CHK (.clk_i, .rst_i, .iface_sel_hi_i,
   .iface_sel_lo_i, .perf_select_i, .power_on_ch1_i, .hold_ch1_i, .select_n_ch1_i,
   .select_n_ch2_i, .step_pulse_ch1_i, .sdio_oe_o, .gain_code_ch1_o, .amp_red_ch1_o,
   .attn_db_ch1_o, .enable_ch1_o, .high_perf_o);

// ### dv/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
   input  wire       sdio_i,
   output reg  [1:0] select_n_o = 2'b11,
   output reg        sclk_o     = 1'b0,
   output reg        sdio_o     = 1'b0
);
   // Clock rests low outside frames; a released line toggles so stale data never passes
   task frame(input [1:0] sel, input [15:0] w, input integer n, input rd_en,
              output [15:0] rd);
      integer i;
      begin
         rd = 16'h0000;
         // Off-grid start keeps every link edge clear of a system clock edge
         #24.3 select_n_o = ~sel;
         #24;
         for (i = 15; i > 15 - n; i = i - 1) begin
            sdio_o = rd_en ? ~sdio_o : w[i[3:0]];
            #24 sclk_o = 1'b1;
            #24 sclk_o = 1'b0;
            rd = {rd[14:0], sdio_i};
         end
         #24 select_n_o = 2'b11;
         #96;
      end
   endtask
endmodule

// ### dv/dual_gain_control_interface_tb_top.sv
`timescale 1ns/1ps
module dual_gain_control_interface_tb_top;
   reg         clk_i, rst_i, perf;
   reg  [1:0]  mode, pwr, hold, qa, pul, dir, gs;
   reg  [5:0]  pa, pb;
   reg  [15:0] rd;
   integer     fail_count, comparisons, s;
   integer     oe_cnt = 0;
   wire        sclk, hsd, dsd, doe, en1, en2, hp;
   wire [1:0]  csn;
   wire [5:0]  g1, g2;
   wire [3:0]  amp1, amp2;
   wire [4:0]  at1, at2;
   wire        sdio_w = doe ? dsd : hsd;
   spi_host_model HOST (.sdio_i(sdio_w), .select_n_o(csn), .sclk_o(sclk), .sdio_o(hsd));
   dual_gain_control_interface DUT (.clk_i(clk_i), .rst_i(rst_i),
      .iface_sel_hi_i(mode[1]), .iface_sel_lo_i(mode[0]), .perf_select_i(perf),
      .power_on_ch1_i(pwr[0]), .power_on_ch2_i(pwr[1]), .par_gain_ch1_i(pa),
      .par_gain_ch2_i(pb), .hold_ch1_i(hold[0]), .hold_ch2_i(hold[1]),
      .select_n_ch1_i(csn[0]), .select_n_ch2_i(csn[1]), .sclk_i(sclk), .sdio_i(sdio_w),
      .sdio_o(dsd), .sdio_oe_o(doe), .quick_atten_pin_ch1_i(qa[0]),
      .quick_atten_pin_ch2_i(qa[1]), .step_pulse_ch1_i(pul[0]), .step_pulse_ch2_i(pul[1]),
      .step_direction_ch1_i(dir[0]), .step_direction_ch2_i(dir[1]), .step_size_hi_i(gs[1]),
      .step_size_lo_i(gs[0]), .gain_code_ch1_o(g1), .gain_code_ch2_o(g2),
      .amp_red_ch1_o(amp1), .amp_red_ch2_o(amp2), .attn_db_ch1_o(at1), .attn_db_ch2_o(at2),
      .enable_ch1_o(en1), .enable_ch2_o(en2), .high_perf_o(hp));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
      if (doe) oe_cnt <= oe_cnt + 1;
   task cyc(input integer n);
      repeat (n) @(posedge clk_i);
   endtask
   task chk(input string nm, input [15:0] e, input [15:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("wrong value %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wcode(input ch, input [5:0] e);
      integer k;
      begin
         for (k = 0; k < 60 && (ch ? g2 : g1) !== e; k = k + 1)
            @(negedge clk_i);
         chk("gain code", e, ch ? g2 : g1);
         if (k == 60)
            print_verdict;
      end
   endtask
   // Direction is held well clear of both pulse edges for the synchroniser
   task pulse(input ch, input dr, input df);
      begin
         @(posedge clk_i) dir[ch] <= dr;
         cyc(4);
         pul[ch] <= 1'b1;
         cyc(4);
         dir[ch] <= df;
         cyc(2);
         pul[ch] <= 1'b0;
         cyc(6);
      end
   endtask
   task step(input [1:0] z, input d, input [5:0] e);
      begin
         @(posedge clk_i) gs <= z;
         pulse(0, d, d);
         wcode(0, e);
      end
   endtask
   task t_parallel;
      begin
         {pa, pb} <= {6'h05, 6'h20};
         wcode(0, 6'h05);
         wcode(1, 6'h20);
         chk("amp ch2", 4'hC, amp2);
         chk("attn ch2", 5'h14, at2);
         @(posedge clk_i) hold <= 2'b01;
         cyc(6);
         {pa, pb} <= {6'h0A, 6'h30};
         wcode(1, 6'h23);
         chk("attn ch2", 5'h17, at2);
         chk("held code", 6'h05, g1);
         @(posedge clk_i) hold <= 2'b00;
         wcode(0, 6'h0A);
         @(posedge clk_i) hold <= 2'b10;
         cyc(6);
         pb <= 6'h07;
         cyc(8);
         chk("held ch2", 6'h23, g2);
         @(posedge clk_i) hold <= 2'b00;
         wcode(1, 6'h07);
      end
   endtask
   task t_serial;
      begin
         @(posedge clk_i) mode <= 2'b01;
         HOST.frame(2'b01, 16'h0054, 16, 1'b0, rd);
         wcode(0, 6'h14);
         HOST.frame(2'b11, 16'hFE03, 16, 1'b0, rd);
         wcode(0, 6'h03);
         wcode(1, 6'h03);
         HOST.frame(2'b10, 16'h0011, 15, 1'b0, rd);
         cyc(20);
         chk("short frame", 6'h03, g2);
         HOST.frame(2'b10, 16'h0011, 17, 1'b0, rd);
         cyc(20);
         chk("long frame", 6'h03, g2);
         HOST.frame(2'b10, 16'h0009, 16, 1'b0, rd);
         wcode(1, 6'h09);
         chk("other channel", 6'h03, g1);
      end
   endtask
   task t_quick;
      begin
         for (s = 0; s < 4; s = s + 1) begin
            HOST.frame(2'b01, {8'h00, s[1:0], 6'h08}, 16, 1'b0, rd);
            wcode(0, 6'h08);
            @(posedge clk_i) qa <= 2'b11;
            wcode(0, 6'h08 + (6'h02 << s));
            chk("quick ch2", 6'h0B, g2);
            @(posedge clk_i) qa <= 2'b00;
            wcode(0, 6'h08);
         end
         HOST.frame(2'b01, 16'h00E0, 16, 1'b0, rd);
         @(posedge clk_i) qa <= 2'b01;
         wcode(0, 6'h23);
         @(posedge clk_i) qa <= 2'b00;
         wcode(0, 6'h20);
      end
   endtask
   task t_power;
      begin
         @(posedge clk_i) pwr <= 2'b10;
         cyc(8);
         chk("sleep ch1", 1'b0, en1);
         chk("awake ch2", 1'b1, en2);
         chk("kept code", 6'h20, g1);
         @(posedge clk_i) {pwr, perf} <= 3'b111;
         cyc(8);
         chk("wake ch1", 1'b1, en1);
         chk("perf high", 1'b1, hp);
         @(posedge clk_i) perf <= 1'b0;
         cyc(8);
         chk("perf low", 1'b0, hp);
      end
   endtask
   task t_readback;
      integer n0;
      begin
         HOST.frame(2'b01, 16'h0154, 16, 1'b0, rd);
         n0 = oe_cnt;
         HOST.frame(2'b01, 16'h0000, 16, 1'b1, rd);
         chk("readback", 16'h0154, rd);
         chk("line driven", 1'b1, oe_cnt > n0);
         n0 = oe_cnt;
         HOST.frame(2'b01, 16'h0000, 16, 1'b1, rd);
         chk("second read", n0[15:0], oe_cnt[15:0]);
      end
   endtask
   task t_updown;
      begin
         @(posedge clk_i) {mode, gs} <= 4'b1011;
         pulse(0, 1'b1, 1'b0);
         wcode(0, 6'h23);
         pulse(1, 1'b0, 1'b1);
         wcode(1, 6'h23);
         for (s = 0; s < 4; s = s + 1)
            pulse(0, 1'b0, 1'b0);
         wcode(0, 6'h1F);
         step(2'b00, 1'b1, 6'h20);
         step(2'b01, 1'b0, 6'h1E);
         step(2'b10, 1'b0, 6'h1A);
         @(posedge clk_i) gs <= 2'b11;
         for (s = 0; s < 4; s = s + 1)
            pulse(0, 1'b0, 1'b0);
         wcode(0, 6'h00);
         @(posedge clk_i) mode <= 2'b11;
         step(2'b00, 1'b1, 6'h01);
      end
   endtask
   task print_verdict;
      begin
         $display("comparisons %0d fail_count %0d", comparisons, fail_count);
         if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      {rst_i, perf} = 2'b10;
      {mode, pwr, hold, qa, pul, dir, gs} = 14'h0C00;
      {pa, pb} = 12'h000;
      {fail_count, comparisons} = 0;
      cyc(11);
      @(negedge clk_i);
      chk("reset code", 6'h3F, g1);
      chk("reset enable", 1'b0, en1);
      @(posedge clk_i) rst_i <= 1'b0;
      cyc(4);
      t_parallel;
      t_serial;
      t_quick;
      t_power;
      t_readback;
      t_updown;
      print_verdict;
   end
endmodule
